/* bench/evseq_mem.sv */
// System bus slave model: byte memory answering after a random lag
`timescale 1ns/100ps
module evseq_mem (
  input  wire logic        aclk,
  input  wire logic        sys_req,
  input  wire logic        sys_we,
  input  wire logic [1:0]  sys_size,
  input  wire logic [31:0] sys_addr,
  input  wire logic [31:0] sys_wdata,
  input  wire logic [1:0]  lag,
  output logic      [31:0] sys_rdata,
  output logic             sys_ack
);
  logic [7:0]  mem [logic [31:0]];
  logic [1:0]  cnt = '0;
  logic [31:0] last = '0;
  // Data lines show the inverted last word while idle so a stale word is never trusted
  always @(posedge aclk) begin
    sys_ack <= 1'b0;
    sys_rdata <= ~last;
    if (sys_req && !sys_ack) begin
      if (cnt < lag) begin
        cnt <= cnt + 2'h1;
      end else begin
        cnt <= '0;
        sys_ack <= 1'b1;
        last = '0;
        for (int i = 0; i < (1 << sys_size); i++) begin
          if (sys_we) begin
            mem[sys_addr + i] = sys_wdata[8*i +: 8];
          end else if (mem.exists(sys_addr + i)) begin
            last[8*i +: 8] = mem[sys_addr + i];
          end
        end
        sys_rdata <= last;
      end
    end
  end
endmodule

/* bench/tb_top.sv */
// Self-checking bench of the event-triggered microsequencer
`timescale 1ns/100ps
`include "evseq_cfg.svh"
module tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic hif = 0, awready, wready, bvalid, arready, rvalid;
  logic clk_on, flag, sys_req, sys_we, sys_ack;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd, ea, eb, ew, eo, rdata;
  logic [31:0] sys_rdata, sys_addr, sys_wdata;
  logic [3:0] ev = 0;
  logic [1:0] lag = 0, sys_size, bresp, rresp, rs;
  logic [23:0] page;
  logic [7:0] r [8];
  logic [7:0] prog [$];
  int fails = 0, checked = 0, seed = 7363;

  evseq_core i_evseq_core (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .rtc_irq(ev[0]), .display_irq(ev[1]),
    .combined_irq(ev[2]), .gpio_irq(ev[3]), .host_interface_irq(hif),
    .sys_clk_on(clk_on), .launch_flag(flag), .sys_req(sys_req),
    .sys_we(sys_we), .sys_size(sys_size), .sys_addr(sys_addr),
    .sys_wdata(sys_wdata), .sys_rdata(sys_rdata), .sys_ack(sys_ack));
  evseq_mem i_evseq_mem (
    .aclk(aclk), .sys_req(sys_req), .sys_we(sys_we),
    .sys_size(sys_size), .sys_addr(sys_addr), .sys_wdata(sys_wdata),
    .lag(lag), .sys_rdata(sys_rdata), .sys_ack(sys_ack));

  // Clock and random answer lag of the memory
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) lag <= 2'($random(seed));

  function automatic logic [31:0] mw(input logic [31:0] a);
    return {i_evseq_mem.mem[a+3], i_evseq_mem.mem[a+2],
            i_evseq_mem.mem[a+1], i_evseq_mem.mem[a]};
  endfunction
  function automatic logic [7:0] bcd(input logic [7:0] x);
    return x[7:4] * 8'd10 + x[3:0];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
  endtask
  task automatic ld(input logic [31:0] a);
    foreach (prog[i]) i_evseq_mem.mem[a + i] = prog[i];
  endtask
  task automatic wf(input logic v, input int n);
    for (int i = 0; i < n && flag !== v; i++) @(posedge aclk);
  endtask
  // One whole run: launch, first fetch, return to idle
  task automatic run(input logic [31:0] b, input logic o);
    wf(1, 60);
    chk("clk_on", 1, clk_on);
    for (int i = 0; i < 20 && !sys_req; i++) @(posedge aclk);
    chk("fetch", b, sys_addr);
    wf(0, 900);
    @(posedge aclk);
    chk("clk_idle", o, clk_on);
  endtask

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    summarize;
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`EVSEQ_OFS_CTRL);
    chk("ctrl", 0, rd);
    axr(`EVSEQ_OFS_STATUS);
    chk("status", 8'h04, rd);
    axw(8'h1C, 0);
    chk("unmapped", `EVSEQ_RESP_SLV, rs);
    prog = '{8'hF8};
    ld(8'h40);
    axw(`EVSEQ_OFS_BASE, 8'h40);
    ev <= 4'hF;
    repeat (5) @(posedge aclk);
    chk("disabled", 0, flag);
    for (int s = 0; s < 4; s++) begin
      ev <= '0;
      axw(`EVSEQ_OFS_OSC, s == 2);
      axw(`EVSEQ_OFS_CTRL, {s[1:0], 1'b1});
      ev <= 4'hF ^ (4'h1 << s);
      repeat (5) @(posedge aclk);
      chk("other_src", 0, flag);
      ev <= 4'hF;
      run(8'h40, s == 2);
    end
    page = 24'($random(seed));
    foreach (r[i]) r[i] = 8'($random(seed));
    ea = {r[3], r[2], r[1], r[0]};
    eb = {r[7], r[6], r[5], r[4]};
    prog = '{8'h00, page[7:0], page[15:8], page[23:16], 8'h08, r[0],
      8'h09, r[1], 8'h0A, r[2], 8'h0B, r[3], 8'h0C, r[4], 8'h0D, r[5],
      8'h0E, r[6], 8'h0F, r[7], 8'h38, 8'h20, 8'h15, 8'h20, 8'h58,
      8'h39, 8'h24, 8'h71, 8'h65, 8'h3C, 8'hF8};
    ld(12'h100);
    ev <= '0;
    axw(`EVSEQ_OFS_BASE, 12'h100);
    axw(`EVSEQ_OFS_CTRL, 1);
    ev <= 4'h1;
    fork
      run(12'h100, 0);
      begin
        wf(1, 60);
        ev <= '0;
        @(posedge aclk) ev <= 4'h1;
      end
    join
    repeat (20) @(posedge aclk);
    chk("relaunch", 0, flag);
    ev <= '0;
    ew = ea;
    eb[15:8] = ea[7:0];
    eb = ea + eb;
    ea = (ea >> 8) + 11'h53C;
    chk("mem_a", ew, mw({page, 8'h20}));
    chk("mem_b", eb, mw({page, 8'h24}));
    axr(`EVSEQ_OFS_DATA_A);
    chk("a1", ea, rd);
    axr(`EVSEQ_OFS_DATA_B);
    chk("b1", eb, rd);
    axr(`EVSEQ_OFS_PAGE);
    chk("page", {page, 8'h00}, rd);
    prog = '{8'h42, 8'h08, 8'h47, 8'h68, 8'h1A, 8'h20, 8'h49, 8'h50,
      8'h20, 8'h24, 8'h78, 8'h08, 8'hFF, 8'hF8};
    ld(12'h200);
    axw(`EVSEQ_OFS_BASE, 12'h200);
    axw(`EVSEQ_OFS_CTRL, 7);
    ev <= 4'h8;
    fork
      run(12'h200, 0);
      begin
        wf(1, 60);
        axw(`EVSEQ_OFS_CTRL, 6);
        repeat (40) @(posedge aclk);
        chk("stall", 1, flag);
        hif <= 1'b1;
      end
    join
    eo = eb;
    ea[7:0] = bcd(8'h47);
    eb[15:0] = ew[15:0];
    eb = ea[7:4] * eb[15:0];
    eb = ea[7:0] * eb[15:0];
    axr(`EVSEQ_OFS_DATA_B);
    chk("b2", eb, rd);
    axr(`EVSEQ_OFS_DATA_A);
    chk("a2", eo, rd);
    summarize;
  end
endmodule

/* core/evseq_alu.sv */
// Arithmetic instructions of the microsequencer
`timescale 1ns/100ps
`include "evseq_cfg.svh"
module evseq_alu
  import evseq_pkg::*;
(
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  input  wire logic [4:0]  op,
  input  wire logic [2:0]  prm,
  input  wire logic [7:0]  imm,
  output logic      [31:0] a_res,
  output logic      [31:0] b_res
);
  logic [3:0]  nib;
  logic [7:0]  byt;
  logic [19:0] nib_prod;
  logic [23:0] byte_prod;
  logic [7:0]  bcd_bin;
  logic [4:0]  shamt;

  // Operand picks and products sized so nothing overflows
  assign nib       = a[{prm, 2'b00} +: 4];
  assign byt       = a[{prm[1:0], 3'b000} +: 8];
  assign nib_prod  = 20'(nib) * 20'(b[15:0]);
  assign byte_prod = 24'(byt) * 24'(b[15:0]);
  assign bcd_bin   = 8'(a[7:4]) * `EVSEQ_BCD_TEN + 8'(a[3:0]);
  assign shamt     = {3'(prm[1:0]) + 3'h1, 2'b00};

  // Results; registers not touched by an opcode pass through
  always_comb begin
    a_res = a;
    b_res = b;
    unique case (op)
      `EVSEQ_OP_NIBMUL:  b_res = {12'h000, nib_prod};
      `EVSEQ_OP_BYTEMUL: b_res = {8'h00, byte_prod};
      `EVSEQ_OP_ADDAB:   b_res = a + b;
      `EVSEQ_OP_ADDIMM:  a_res = a + {21'h00_0000, prm, imm};
      `EVSEQ_OP_BCD:     a_res = {a[31:8], bcd_bin};
      `EVSEQ_OP_SHIFT:   a_res = a >> shamt;
      default: begin
        a_res = a;
        b_res = b;
      end
    endcase
  end
endmodule

/* core/evseq_cfg.svh */
// Constants of the event-triggered microsequencer
`ifndef EVSEQ_CFG_SVH
`define EVSEQ_CFG_SVH
// Register byte offsets on the AXI4-Lite slave
`define EVSEQ_OFS_CTRL   8'h00
`define EVSEQ_OFS_BASE   8'h04
`define EVSEQ_OFS_OSC    8'h08
`define EVSEQ_OFS_STATUS 8'h0C
`define EVSEQ_OFS_DATA_A 8'h10
`define EVSEQ_OFS_DATA_B 8'h14
`define EVSEQ_OFS_PAGE   8'h18
// Field positions
`define EVSEQ_CTRL_EN    0
`define EVSEQ_CTRL_SEL   2:1
`define EVSEQ_OSC_EN     0
// Reset values
`define EVSEQ_RST_BASE   32'h0000_0000
`define EVSEQ_RST_SEL    2'h0
// Opcodes
`define EVSEQ_OP_PAGE    5'h00
`define EVSEQ_OP_IMM8    5'h01
`define EVSEQ_OP_RD8     5'h02
`define EVSEQ_OP_RD16    5'h03
`define EVSEQ_OP_RD32    5'h04
`define EVSEQ_OP_WR8     5'h05
`define EVSEQ_OP_WR16    5'h06
`define EVSEQ_OP_WR32    5'h07
`define EVSEQ_OP_WAIT    5'h08
`define EVSEQ_OP_NIBMUL  5'h09
`define EVSEQ_OP_BYTEMUL 5'h0A
`define EVSEQ_OP_ADDAB   5'h0B
`define EVSEQ_OP_ADDIMM  5'h0C
`define EVSEQ_OP_BCD     5'h0D
`define EVSEQ_OP_SHIFT   5'h0E
`define EVSEQ_OP_END     5'h1F
// Parameter bytes after the instruction byte
`define EVSEQ_LEN_NONE   2'h0
`define EVSEQ_LEN_ONE    2'h1
`define EVSEQ_LEN_PAGE   2'h3
// Bus access sizes and misc constants
`define EVSEQ_SZ_BYTE    2'h0
`define EVSEQ_SZ_HALF    2'h1
`define EVSEQ_SZ_WORD    2'h2
`define EVSEQ_PC_STEP    32'h0000_0001
`define EVSEQ_BCD_TEN    8'h0A
`define EVSEQ_RESP_OKAY  2'h0
`define EVSEQ_RESP_SLV   2'h2
`endif

/* core/evseq_core.sv */
// Event-triggered microsequencer with AXI4-Lite registers
//
// Overview of operation
// - Reset: launching disabled, sequencer idle.
// - Two-bit select picks launch source.
// - Launch on rising edge, not level.
// - Launch: clock on, fetch from base.
// - Sequential fetch; end or invalid stops.
// - Clock off at idle unless oscillator enabled; code turns it off only as a run ends, not on clearing the enable.
// - Edges during a run are dropped.
// - Disabling launch never aborts a run.
// - Two 32-bit data registers, 24-bit page.
// - Byte: five-bit opcode, three-bit parameter.
// - Page load from three bytes, low first.
// - Immediate byte into chosen lane.
// - Byte read from page plus offset.
// - Half and word reads into A/B.
// - Byte, half, word writes from A/B.
// - Wait stalls until chosen event high.
// - Nibble or byte of A times B.
// - Add A to B; add immediate to A.
// - Two BCD digits to binary.
// - Shift A right by 4 to 16.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "evseq_cfg.svh"
module evseq_core
  import evseq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  input  wire logic        rtc_irq,
  input  wire logic        display_irq,
  input  wire logic        combined_irq,
  input  wire logic        gpio_irq,
  input  wire logic        host_interface_irq,
  output logic             sys_clk_on,
  output logic             launch_flag,
  output logic             sys_req,
  output logic             sys_we,
  output logic      [1:0]  sys_size,
  output logic      [31:0] sys_addr,
  output logic      [31:0] sys_wdata,
  input  wire logic [31:0] sys_rdata,
  input  wire logic        sys_ack
);
  evseq_core_type r;
  evseq_core_type n;
  logic           launch_rise;
  logic           wait_level;
  logic [4:0]     op;
  logic [2:0]     par;
  logic [7:0]     prm;
  logic [31:0]    alu_a;
  logic [31:0]    alu_b;
  logic [31:0]    src;
  logic [1:0]     len;
  logic           stop_op;
  logic [7:0]     aw_word;
  logic [7:0]     ar_word;
  logic [31:0]    lane_src;

  assign op  = r.inst[7:3];
  assign par = r.inst[2:0];
  assign prm = r.opnd[23:16];

  // anything past the shift opcode stops
  assign stop_op = (sys_rdata[7:3] > `EVSEQ_OP_SHIFT);

  // Parameter bytes that follow each opcode
  always_comb begin
    unique case (sys_rdata[7:3])
      `EVSEQ_OP_PAGE: len = `EVSEQ_LEN_PAGE;
      `EVSEQ_OP_IMM8, `EVSEQ_OP_RD8, `EVSEQ_OP_RD16, `EVSEQ_OP_RD32,
      `EVSEQ_OP_WR8, `EVSEQ_OP_WR16, `EVSEQ_OP_WR32,
      `EVSEQ_OP_ADDIMM: len = `EVSEQ_LEN_ONE;
      default: len = `EVSEQ_LEN_NONE;
    endcase
  end

  // Byte stores pick A or B by parameter bit 2
  assign lane_src = par[2] ? r.b : r.a;

  // store source by size and parameter
  always_comb begin
    unique case (op)
      `EVSEQ_OP_WR8:
        src = {24'h00_0000, lane_src[{par[1:0], 3'b000} +: 8]};
      `EVSEQ_OP_WR16:
        src = {16'h0000, (par[1] ? r.b[15:0] : r.a[15:0])};
      default: src = par[0] ? r.b : r.a;
    endcase
  end

  evseq_event_select u_event (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .rtc_irq            (rtc_irq),
    .display_irq        (display_irq),
    .combined_irq       (combined_irq),
    .gpio_irq           (gpio_irq),
    .host_interface_irq (host_interface_irq),
    .launch_sel         (r.sel),
    .wait_sel           (par[1:0]),
    // armed only while idle; a run is never cut
    .arm                (r.launch_enable && r.st == st_idle),
    .launch_rise        (launch_rise),
    .wait_level         (wait_level)
  );

  evseq_alu u_alu (
    .a     (r.a),
    .b     (r.b),
    .op    (op),
    .prm   (par),
    .imm   (prm),
    .a_res (alu_a),
    .b_res (alu_b)
  );

  // Word-aligned register index of the held write address and the incoming read address
  assign aw_word = {r.awaddr[7:2], 2'b00};
  assign ar_word = {s_axi_araddr[7:2], 2'b00};

  // Next state of bus slave and sequencer
  always_comb begin
    n = r;
    // Address and data may come in either order
    if (s_axi_awvalid && !r.aw_held) begin
      n.aw_held = 1'b1;
      n.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_held) begin
      n.w_held    = 1'b1;
      n.axi_wdata = s_axi_wdata;
      n.wstrb     = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // Write commits only once the previous response is gone
    if (r.aw_held && r.w_held && !r.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `EVSEQ_RESP_OKAY;
      if (aw_word == `EVSEQ_OFS_CTRL) begin
        if (r.wstrb[0]) begin
          n.launch_enable = r.axi_wdata[`EVSEQ_CTRL_EN];
          n.sel           = r.axi_wdata[`EVSEQ_CTRL_SEL];
        end
      end else if (aw_word == `EVSEQ_OFS_BASE) begin
        for (int i = 0; i < 4; i++) begin
          if (r.wstrb[i]) begin
            n.base[i*8 +: 8] = r.axi_wdata[i*8 +: 8];
          end
        end
      end else if (aw_word == `EVSEQ_OFS_OSC) begin
        if (r.wstrb[0]) begin
          n.osc_en = r.axi_wdata[`EVSEQ_OSC_EN];
        end
      end else begin
        // Status and data views are read-only
        n.bresp = `EVSEQ_RESP_SLV;
      end
    end
    // Read channel: one answer outstanding
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = `EVSEQ_RESP_OKAY;
      n.rdata  = 32'h0000_0000;
      unique case (ar_word)
        `EVSEQ_OFS_CTRL:
          n.rdata[2:0] = {r.sel, r.launch_enable};
        `EVSEQ_OFS_BASE:   n.rdata = r.base;
        `EVSEQ_OFS_OSC:    n.rdata[0] = r.osc_en;
        `EVSEQ_OFS_STATUS: n.rdata[7:0] = {r.st, r.clk_on, r.flag};
        `EVSEQ_OFS_DATA_A: n.rdata = r.a;
        `EVSEQ_OFS_DATA_B: n.rdata = r.b;
        `EVSEQ_OFS_PAGE:   n.rdata = {r.page, 8'h00};
        default:           n.rresp = `EVSEQ_RESP_SLV;
      endcase
    end
    // Sequencer
    unique case (r.st)
      st_idle: begin
        // start the run at the base address
        if (launch_rise) begin
          n.st     = st_fetch;
          n.flag   = 1'b1;
          n.clk_on = 1'b1;
          n.pc     = r.base;
        end
      end
      st_fetch: begin
        if (!r.req) begin
          n.req  = 1'b1;
          n.we   = 1'b0;
          n.size = `EVSEQ_SZ_BYTE;
          n.addr = r.pc;
        end else if (sys_ack) begin
          n.req  = 1'b0;
          n.pc   = r.pc + `EVSEQ_PC_STEP;
          n.inst = sys_rdata[7:0];
          n.cnt  = len;
          if (stop_op) begin
            n.st   = st_idle;
            n.flag = 1'b0;
            if (!r.osc_en) begin
              n.clk_on = 1'b0;
            end
          end else if (len != `EVSEQ_LEN_NONE) begin
            n.st = st_parm;
          end else begin
            n.st = st_exec;
          end
        end
      end
      st_parm: begin
        if (!r.req) begin
          n.req  = 1'b1;
          n.we   = 1'b0;
          n.size = `EVSEQ_SZ_BYTE;
          n.addr = r.pc;
        end else if (sys_ack) begin
          n.req = 1'b0;
          n.pc  = r.pc + `EVSEQ_PC_STEP;
          // bytes shift in from the top
          n.opnd = {sys_rdata[7:0], r.opnd[23:8]};
          n.cnt  = r.cnt - `EVSEQ_LEN_ONE;
          if (r.cnt == `EVSEQ_LEN_ONE) begin
            n.st = st_exec;
          end
        end
      end
      st_exec: begin
        n.st = st_fetch;
        unique case (op)
          `EVSEQ_OP_PAGE: n.page = r.opnd;
          `EVSEQ_OP_IMM8: begin
            if (par[2]) begin
              n.b[{par[1:0], 3'b000} +: 8] = prm;
            end else begin
              n.a[{par[1:0], 3'b000} +: 8] = prm;
            end
          end
          `EVSEQ_OP_RD8, `EVSEQ_OP_RD16, `EVSEQ_OP_RD32,
          `EVSEQ_OP_WR8, `EVSEQ_OP_WR16, `EVSEQ_OP_WR32: n.st = st_mem;
          `EVSEQ_OP_WAIT: n.st = st_wait;
          default: begin
            n.a = alu_a;
            n.b = alu_b;
          end
        endcase
      end
      st_mem: begin
        if (!r.req) begin
          // page on top of the offset
          n.req   = 1'b1;
          n.addr  = {r.page, prm};
          n.we    = (op >= `EVSEQ_OP_WR8);
          n.wdata = src;
          if (op == `EVSEQ_OP_RD16 || op == `EVSEQ_OP_WR16) begin
            n.size = `EVSEQ_SZ_HALF;
          end else if (op == `EVSEQ_OP_RD32 || op == `EVSEQ_OP_WR32) begin
            n.size = `EVSEQ_SZ_WORD;
          end else begin
            n.size = `EVSEQ_SZ_BYTE;
          end
        end else if (sys_ack) begin
          n.req = 1'b0;
          n.st  = st_fetch;
          // read data into A or B
          if (op == `EVSEQ_OP_RD8 && par[2]) begin
            n.b[{par[1:0], 3'b000} +: 8] = sys_rdata[7:0];
          end else if (op == `EVSEQ_OP_RD8) begin
            n.a[{par[1:0], 3'b000} +: 8] = sys_rdata[7:0];
          end else if (op == `EVSEQ_OP_RD16 && par[1]) begin
            n.b[15:0] = sys_rdata[15:0];
          end else if (op == `EVSEQ_OP_RD16) begin
            n.a[15:0] = sys_rdata[15:0];
          end else if (op == `EVSEQ_OP_RD32 && par[0]) begin
            n.b = sys_rdata;
          end else if (op == `EVSEQ_OP_RD32) begin
            n.a = sys_rdata;
          end
        end
      end
      st_wait: begin
        // no fetch until the event is high
        if (wait_level) begin
          n.st = st_fetch;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r      <= '0;
      r.st   <= st_idle;
      r.sel  <= `EVSEQ_RST_SEL;
      r.base <= `EVSEQ_RST_BASE;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flops; readies reflect free holding slots
  assign s_axi_awready = !r.aw_held;
  assign s_axi_wready  = !r.w_held;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign sys_clk_on    = r.clk_on;
  assign launch_flag   = r.flag;
  assign sys_req       = r.req;
  assign sys_we        = r.we;
  assign sys_size      = r.size;
  assign sys_addr      = r.addr;
  assign sys_wdata     = r.wdata;

  property p_reset_idle;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> r.st == st_idle && !r.launch_enable && !r.flag;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("not idle and disabled after reset");

  property p_launch_start;
    @(posedge aclk) disable iff (!aresetn)
      (r.st == st_idle && launch_rise)
        |=> r.st == st_fetch && r.pc == $past(r.base) && sys_clk_on
            ##1 sys_req && sys_addr == $past(r.base, 2);
  endproperty
  a_launch_start: assert property (p_launch_start)
    else $error("launch did not fetch from base with clock on");

  property p_no_level_launch;
    @(posedge aclk) disable iff (!aresetn)
      (r.st == st_idle && $past(r.st == st_idle) && $stable(r.sel)
       && $past(u_event.lvl) && u_event.lvl) |=> r.st == st_idle;
  endproperty
  a_no_level_launch: assert property (p_no_level_launch)
    else $error("steady high source launched a run");

  property p_end_idle;
    @(posedge aclk) disable iff (!aresetn)
      (r.st == st_fetch && r.req && sys_ack && stop_op)
        |=> r.st == st_idle && !launch_flag
            && (sys_clk_on == $past(r.osc_en || !r.clk_on ? r.clk_on
                                                           : 1'b0));
  endproperty
  a_end_idle: assert property (p_end_idle)
    else $error("stop opcode did not return to idle");

  property p_clock_off;
    @(posedge aclk) disable iff (!aresetn)
      (r.st == st_fetch && r.req && sys_ack && stop_op && !r.osc_en)
        |=> !sys_clk_on;
  endproperty
  a_clock_off: assert property (p_clock_off)
    else $error("clock left on with oscillator disabled");

  property p_run_holds;
    @(posedge aclk) disable iff (!aresetn)
      (r.st != st_idle && !(r.st == st_fetch && sys_ack && stop_op))
        |=> r.st != st_idle && launch_flag;
  endproperty
  a_run_holds: assert property (p_run_holds)
    else $error("run ended without a stop opcode");

  property p_no_queue;
    @(posedge aclk) disable iff (!aresetn)
      (r.st != st_idle && u_event.lvl && !u_event.r.prev)
        |=> !(r.st == st_fetch && r.pc == r.base && $past(r.st) == st_idle);
  endproperty
  a_no_queue: assert property (p_no_queue)
    else $error("edge during a run started a launch");

  property p_page_load;
    @(posedge aclk) disable iff (!aresetn)
      (r.st == st_exec && op == `EVSEQ_OP_PAGE) |=> r.page == $past(r.opnd);
  endproperty
  a_page_load: assert property (p_page_load)
    else $error("page register not loaded from operands");

  property p_mem_addr;
    @(posedge aclk) disable iff (!aresetn)
      (r.st == st_mem && r.req) |-> sys_addr == {r.page, prm};
  endproperty
  a_mem_addr: assert property (p_mem_addr)
    else $error("memory access address not page plus offset");

  property p_wait_stall;
    @(posedge aclk) disable iff (!aresetn)
      (r.st == st_wait && !wait_level) |=> r.st == st_wait && !sys_req;
  endproperty
  a_wait_stall: assert property (p_wait_stall)
    else $error("fetch resumed before the awaited event");
endmodule

/* core/evseq_event_select.sv */
// Event source selection and rising-edge detection
`timescale 1ns/100ps
`include "evseq_cfg.svh"
module evseq_event_select
  import evseq_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       rtc_irq,
  input  wire logic       display_irq,
  input  wire logic       combined_irq,
  input  wire logic       gpio_irq,
  input  wire logic       host_interface_irq,
  input  wire logic [1:0] launch_sel,
  input  wire logic [1:0] wait_sel,
  input  wire logic       arm,
  output logic            launch_rise,
  output logic            wait_level
);
  evseq_edge_type r;
  evseq_edge_type n;
  logic           lvl;

  // Launch source: rtc, display, combined, gpio
  always_comb begin
    unique case (launch_sel)
      2'h0: lvl = rtc_irq;
      2'h1: lvl = display_irq;
      2'h2: lvl = combined_irq;
      default: lvl = gpio_irq;
    endcase
  end

  // Wait source: host interface replaces the combined line
  always_comb begin
    unique case (wait_sel)
      2'h0: wait_level = rtc_irq;
      2'h1: wait_level = display_irq;
      2'h2: wait_level = host_interface_irq;
      default: wait_level = gpio_irq;
    endcase
  end

  // History always tracks, so a level high when arming is not an edge
  always_comb begin
    n      = r;
    n.prev = lvl;
  end

  assign launch_rise = arm && lvl && !r.prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

/* core/evseq_pkg.sv */
// Types of the event-triggered microsequencer
package evseq_pkg;
  typedef enum logic [5:0] {
    st_idle  = 6'h01,
    st_fetch = 6'h02,
    st_parm  = 6'h04,
    st_exec  = 6'h08,
    st_mem   = 6'h10,
    st_wait  = 6'h20
  } evseq_state_type;

  typedef struct packed {
    logic            prev;
  } evseq_edge_type;

  typedef struct packed {
    evseq_state_type st;
    logic            launch_enable;
    logic [1:0]      sel;
    logic [31:0]     base;
    logic            osc_en;
    logic            flag;
    logic            clk_on;
    logic [31:0]     pc;
    logic [7:0]      inst;
    logic [23:0]     opnd;
    logic [1:0]      cnt;
    logic [31:0]     a;
    logic [31:0]     b;
    logic [23:0]     page;
    logic            req;
    logic            we;
    logic [1:0]      size;
    logic [31:0]     addr;
    logic [31:0]     wdata;
    logic            aw_held;
    logic [7:0]      awaddr;
    logic            w_held;
    logic [31:0]     axi_wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } evseq_core_type;
endpackage
